// ---- rtl/eil_defines.vh ----
// Overview of operation
// - a low external pin latches a request per the trigger sensitivity
// - vector fetch makes an acknowledge that clears the request latch
// - writing 1 to the acknowledge bit clears the latch like vector fetch
// - system reset clears the request latch
// - trigger select bit 0: 1 edge and level, 0 falling edge only
// - level mode clears only after acknowledge and pin high, either order
// - edge mode: an acknowledge clears the latch at once unless a falling edge comes in the same cycle
// - falling edge after an acknowledge write latches a new request
// - mask bit 1 withholds the request; latch keeps its state
// - serviced request supplies vector from FFFA high and FFFB low
// - acknowledge bit is write only and reads 0
// - read-only event flag reads 1 when an event occurred
// - reset clears trigger select and mask bits
// - present pin level exposed for branch on pin high or low
`ifndef EIL_DEFINES_VH
`define EIL_DEFINES_VH
`define EIL_REG_INDEX   14'h003f
`define EIL_BYTE_ADDR   14'h00fc
`define EIL_BIT_MODE    0
`define EIL_BIT_MASK    1
`define EIL_BIT_ACK     2
`define EIL_BIT_FLAG    3
`define EIL_RESET_VAL   8'h00
`define EIL_VEC_HI_ADDR 16'hfffa
`define EIL_VEC_LO_ADDR 16'hfffb
`define EIL_RESP_OKAY   2'b00
`define EIL_RESP_SLVERR 2'b10
`endif

// ---- rtl/eil_external_interrupt_latch.v ----
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "eil_defines.vh"
module eil_external_interrupt_latch (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        extIrqPin_n,
	input  wire        vectorFetchAck,
	input  wire [7:0]  vectorHighByte,
	input  wire [7:0]  vectorLowByte,
	output reg         extRequest,
	output reg         pinLevel,
	output reg  [15:0] vectorAddr,
	output reg  [15:0] vectorValue,
	input  wire [31:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [31:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);

// ------------------------------------------------------------
// pin synchroniser
// ------------------------------------------------------------
reg        pinSync1;
reg        pinSync2;
reg        pinPrev;
wire       fallEdge;

always @(posedge clk) begin
	if (!rst_n) begin
		pinSync1 <= 1'b1;
		pinSync2 <= 1'b1;
		pinPrev  <= 1'b1;
	end else begin
		pinSync1 <= extIrqPin_n;
		pinSync2 <= pinSync1;
		pinPrev  <= pinSync2;
	end
end

assign fallEdge = pinPrev & ~pinSync2;

// ------------------------------------------------------------
// axi write channel
// ------------------------------------------------------------
reg  [31:0] awAddr;
reg         awHeld;
reg  [31:0] wData;
reg  [3:0]  wStrb;
reg         wHeld;
wire        doWrite;
wire        wrHit;
wire        swAck;
wire        cfgWrite;

assign doWrite  = awHeld & wHeld & ~s_axi_bvalid;
assign wrHit    = (awAddr[15:2] == `EIL_REG_INDEX);
assign cfgWrite = doWrite & wrHit & wStrb[0];
assign swAck    = cfgWrite & wData[`EIL_BIT_ACK];

always @(posedge clk) begin
	if (!rst_n) begin
		awHeld        <= 1'b0;
		wHeld         <= 1'b0;
		awAddr        <= 32'h0000_0000;
		wData         <= 32'h0000_0000;
		wStrb         <= 4'h0;
		s_axi_awready <= 1'b0;
		s_axi_wready  <= 1'b0;
		s_axi_bvalid  <= 1'b0;
		s_axi_bresp   <= `EIL_RESP_OKAY;
	end else begin
		s_axi_awready <= ~awHeld & ~s_axi_awready & s_axi_awvalid;
		s_axi_wready  <= ~wHeld & ~s_axi_wready & s_axi_wvalid;
		if (s_axi_awvalid & s_axi_awready) begin
			awHeld <= 1'b1;
			awAddr <= s_axi_awaddr;
		end
		if (s_axi_wvalid & s_axi_wready) begin
			wHeld <= 1'b1;
			wData <= s_axi_wdata;
			wStrb <= s_axi_wstrb;
		end
		if (doWrite) begin
			awHeld       <= 1'b0;
			wHeld        <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wrHit ? `EIL_RESP_OKAY : `EIL_RESP_SLVERR;
		end else if (s_axi_bvalid & s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

// ------------------------------------------------------------
// control bits and request latch
// ------------------------------------------------------------
reg  levelTriggerSelect;
reg  extRequestMask;
reg  extRequestLatch;
reg  extEventFlag;
reg  ackSeen;
wire anyAck;
wire setReq;

assign anyAck = swAck | vectorFetchAck;
// level mode latches while pin is low, edge mode only on a fall
assign setReq = fallEdge | (levelTriggerSelect & ~pinSync2);

always @(posedge clk) begin
	if (!rst_n) begin
		levelTriggerSelect <= 1'b0;
		extRequestMask     <= 1'b0;
		extRequestLatch    <= 1'b0;
		extEventFlag       <= 1'b0;
		ackSeen            <= 1'b0;
	end else begin
		if (cfgWrite) begin
			levelTriggerSelect <= wData[`EIL_BIT_MODE];
			extRequestMask     <= wData[`EIL_BIT_MASK];
		end
		if (levelTriggerSelect) begin
			// needs both acknowledge and pin high, any order
			if (anyAck | ackSeen) begin
				if (pinSync2 & ~fallEdge) begin
					extRequestLatch <= 1'b0;
					ackSeen         <= 1'b0;
				end else begin
					ackSeen <= extRequestLatch | setReq;
				end
			end
			if (setReq & ~(anyAck | ackSeen))
				extRequestLatch <= 1'b1;
		end else begin
			ackSeen <= 1'b0;
			if (fallEdge)
				extRequestLatch <= 1'b1;
			else if (anyAck)
				extRequestLatch <= 1'b0;
		end
		if (setReq)
			extEventFlag <= 1'b1;
		else if (anyAck)
			extEventFlag <= 1'b0;
	end
end

// ------------------------------------------------------------
// cpu side outputs
// ------------------------------------------------------------
always @(posedge clk) begin
	if (!rst_n) begin
		extRequest  <= 1'b0;
		pinLevel    <= 1'b1;
		vectorAddr  <= `EIL_VEC_HI_ADDR;
		vectorValue <= 16'h0000;
	end else begin
		extRequest  <= extRequestLatch & ~extRequestMask;
		pinLevel    <= pinSync2;
		vectorAddr  <= `EIL_VEC_HI_ADDR;
		vectorValue <= {vectorHighByte, vectorLowByte};
	end
end

// ------------------------------------------------------------
// axi read channel
// ------------------------------------------------------------
wire [7:0] statusByte;

assign statusByte = {4'h0, extEventFlag, 1'b0,
	extRequestMask, levelTriggerSelect};

always @(posedge clk) begin
	if (!rst_n) begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid  <= 1'b0;
		s_axi_rdata   <= 32'h0000_0000;
		s_axi_rresp   <= `EIL_RESP_OKAY;
	end else begin
		s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
		if (s_axi_arvalid & s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			if (s_axi_araddr[15:2] == `EIL_REG_INDEX) begin
				s_axi_rdata <= {24'h00_0000, statusByte};
				s_axi_rresp <= `EIL_RESP_OKAY;
			end else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= `EIL_RESP_SLVERR;
			end
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
end

endmodule

// ---- bench/eil_latch_chk.sv ----
`timescale 1ns/1ps
module eil_latch_chk (
	input wire        clk,
	input wire        rst_n,
	input wire        extIrqPin_n,
	input wire        vectorFetchAck,
	input wire [7:0]  vectorHighByte,
	input wire [7:0]  vectorLowByte,
	input wire        extRequest,
	input wire        pinLevel,
	input wire [15:0] vectorAddr,
	input wire [15:0] vectorValue,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_vec_addr: assert property (vectorAddr == 16'hfffa)
		else $error("vector address wrong");
	a_vec_value: assert property ($past(rst_n) |->
		vectorValue == {$past(vectorHighByte), $past(vectorLowByte)})
		else $error("vector value wrong");
	a_pin_level: assert property ($stable(extIrqPin_n)[*4] |->
		pinLevel == extIrqPin_n) else $error("pin level wrong");
	a_ack_clear: assert property (
		(extIrqPin_n && pinLevel)[*3] ##0 vectorFetchAck |-> ##2 !extRequest)
		else $error("fetch kept request");
	a_reset_clear: assert property (disable iff (1'b0)
		!rst_n |=> !extRequest) else $error("reset kept request");
	a_read_zero: assert property (s_axi_rvalid |->
		!(|{s_axi_rdata[31:8], s_axi_rdata[2]})) else $error("read bits set");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
endmodule
bind eil_external_interrupt_latch eil_latch_chk chk_u (.*);

// ---- bench/eil_cpu_model.sv ----
`timescale 1ns/1ps
module eil_cpu_model (
	input  wire clk,
	input  wire rst_n,
	input  wire serve,
	input  wire extRequest,
	output reg  vectorFetchAck
);
	reg ackOld;
	// one fetch pulse every third cycle while a request is served, the pause letting the latch drop
	always @(posedge clk) begin
		ackOld <= vectorFetchAck;
		vectorFetchAck <= rst_n & serve & extRequest & ~vectorFetchAck & ~ackOld;
	end
endmodule

// ---- bench/eil_tb.sv ----
`timescale 1ns/1ps
`include "eil_defines.vh"
module testbench;
	localparam [31:0] RA = 32'(`EIL_BYTE_ADDR);
	reg        clk = 0, rst_n = 0, pin = 1, sv = 0;
	reg        awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	reg [7:0]  hi = 0, lo = 0;
	reg [31:0] addr = 0, wd = 0, d;
	reg [1:0]  r, b;
	wire [1:0] bresp;
	wire [15:0] va, vv;
	integer    seed = 11, cyc = 0, miscompares = 0, cmp_count = 0;
	wire       ack, req, lvl, awrdy, wrdy, bv, arr, rv;
	wire [1:0] rresp;
	wire [31:0] rdata;
	eil_external_interrupt_latch dut_u (.clk(clk), .rst_n(rst_n),
		.extIrqPin_n(pin), .vectorFetchAck(ack), .vectorHighByte(hi),
		.vectorLowByte(lo), .extRequest(req), .pinLevel(lvl),
		.vectorAddr(va), .vectorValue(vv), .s_axi_awaddr(addr),
		.s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(addr), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rr));
	eil_cpu_model cpu_u (.clk(clk), .rst_n(rst_n), .serve(sv),
		.extRequest(req), .vectorFetchAck(ack));
	always #5 clk = ~clk;
	task stop_test;
		$display("compares %0d wrong %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			miscompares++;
			stop_test;
		end
	end
	task chk(input string n, input [31:0] s, input [31:0] e);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %s exp %h got %h", n, e, s);
		end
	endtask
	task w(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task wr(input [31:0] a, input [31:0] v);
		addr <= a;
		wd <= v;
		awv <= 1;
		wv <= 1;
		@(posedge clk);
		while (awv || wv) begin
			if (awrdy) awv <= 0;
			if (wrdy) wv <= 0;
			@(posedge clk);
		end
		while (!bv) @(posedge clk);
		b = bresp;
		br <= 1;
		@(posedge clk);
		br <= 0;
	endtask
	task rd(input [31:0] a);
		addr <= a;
		arv <= 1;
		@(posedge clk);
		while (!arr) @(posedge clk);
		arv <= 0;
		while (!rv) @(posedge clk);
		rr <= 1;
		@(posedge clk);
		d = rdata;
		r = rresp;
		rr <= 0;
	endtask
	initial begin
		w(10);
		rst_n <= 1;
		w(1);
		rd(RA);
		chk("reg", d, 0);
		chk("pin", lvl, 1);
		pin <= 0;
		w(6);
		chk("req", req, 1);
		rd(RA);
		chk("flag", d, 8);
		wr(RA, 4);
		chk("bresp", b, `EIL_RESP_OKAY);
		w(3);
		chk("req", req, 0);
		pin <= 1;
		w(4);
		pin <= 0;
		w(6);
		chk("req", req, 1);
		wr(RA, 2);
		w(3);
		chk("req", req, 0);
		wr(RA, 0);
		w(3);
		chk("req", req, 1);
		pin <= 1;
		w(5);
		sv <= 1;
		w(6);
		chk("req", req, 0);
		wr(RA, 1);
		pin <= 0;
		w(12);
		chk("req", req, 1);
		sv <= 0;
		pin <= 1;
		w(6);
		chk("req", req, 0);
		rd(0);
		chk("resp", r, `EIL_RESP_SLVERR);
		wr(0, 6);
		chk("bresp", b, `EIL_RESP_SLVERR);
		rd(RA);
		chk("reg", d, 9);
		repeat (8) begin
			hi <= 8'($random(seed));
			lo <= 8'($random(seed));
			w(2);
			chk("vec", vv, {hi, lo});
			chk("vaddr", va, `EIL_VEC_HI_ADDR);
		end
		stop_test;
	end
endmodule
